/* File: verilog/ifer_pkg.sv */
// constants and carriers for the interrupt flag/enable register block
// assumes a single 125 MHz clock and a plain strobe register port
//
// Contract
// - Software sets or clears one enable bit per external pin one and two, gating that pin's interrupt.
// - Every flag sets on its event regardless of its own enable and of the global enable.
// - Unimplemented bits read as zero and ignore writes.
// - The parallel port flag in bit 7 sets when an external port access completes and only software clears it.
// - On 28-pin variants the parallel port flag is unimplemented and reads as zero.
// - The conversion flag sets when a conversion finishes and stays set until software clears it.
// - The serial receive flag is read-only and mirrors a full receive buffer, cleared by reading the buffer.
// - The serial transmit flag is read-only and high while the transmit buffer is empty, cleared by writing it.
// - The sync serial flag sets when a transfer completes and stays set until software clears it.
// - The capture/compare flag sets on capture or compare match and is unused in pulse-width mode.
// - The timer two flag sets when its count equals the period value and stays set until cleared.
// - The timer one flag sets when its count overflows and stays set until cleared.
package ifer_pkg;
	localparam logic [1:0] IFER_OFS_XCTL  = 2'h0;
	localparam logic [1:0] IFER_OFS_PFLG  = 2'h1;
	localparam logic [1:0] IFER_OFS_PEN   = 2'h2;
	localparam logic [1:0] IFER_OFS_GCTL  = 2'h3;
	localparam int IFER_XCTL_P2 = 7;
	localparam int IFER_XCTL_P1 = 6;
	localparam int IFER_XCTL_E2 = 4;
	localparam int IFER_XCTL_E1 = 3;
	localparam int IFER_XCTL_F2 = 1;
	localparam int IFER_XCTL_F1 = 0;
	localparam logic [7:0] IFER_XCTL_WMASK = 8'hdb;
	localparam logic [7:0] IFER_XCTL_RST   = 8'hc0;
	localparam int IFER_PF_PAR = 7;
	localparam int IFER_PF_ADC = 6;
	localparam int IFER_PF_RX  = 5;
	localparam int IFER_PF_TX  = 4;
	localparam int IFER_PF_SSP = 3;
	localparam int IFER_PF_CCP = 2;
	localparam int IFER_PF_T2  = 1;
	localparam int IFER_PF_T1  = 0;
	localparam logic [7:0] IFER_PFLG_RST  = 8'h00;
	localparam logic [7:0] IFER_PFLG_STKY = 8'hcf;
	localparam logic [7:0] IFER_PEN_RST   = 8'h00;
	localparam logic [7:0] IFER_GCTL_RST  = 8'h00;
	localparam int IFER_SYNC_STAGES = 2;

	// peripheral event pulses, one cycle each, same clock
	typedef struct packed {
		logic par_done;
		logic adc_done;
		logic ssp_done;
		logic ccp_event;
		logic t2_match;
		logic t1_ovf;
	} ifer_evt_s;

	// requests toward the core
	typedef struct packed {
		logic hi;
		logic lo;
	} ifer_req_s;
endpackage

/* File: verilog/ifer_edge.sv */
// synchroniser and rising edge detector for one external interrupt pin
// assumes pin is asynchronous to ref_clk
`timescale 1ns/10ps
`default_nettype none
module ifer_edge import ifer_pkg::*; (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic reset_n,
	// pin and event
	input  wire logic pin,
	output logic      pulse
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} ifer_edge_s;
	ifer_edge_s st_q, st_d;

	always_comb begin
		st_d = st_q;
		st_d.s1 = pin;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign pulse = st_q.s2 & ~st_q.s3;
endmodule
`default_nettype wire

/* File: verilog/ifer_top.sv */
// interrupt flag, enable and priority registers for two external pins
// and the first peripheral flag bank; assumes event pulses from peripherals
// on ref_clk and a strobe register port with read data one cycle later
`timescale 1ns/10ps
`default_nettype none
module ifer_top import ifer_pkg::*; #(
	parameter bit PIN28 = 1'b0
) (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	// register port
	input  wire logic [1:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// external pins
	input  wire logic       ext_pin1,
	input  wire logic       ext_pin2,
	// peripheral events and buffer states
	input  wire ifer_evt_s  evt,
	input  wire logic       rx_buf_full,
	input  wire logic       tx_buf_empty,
	input  wire logic       pwm_mode,
	// requests toward the core
	output ifer_req_s       req,
	output logic            irq
);
	typedef struct packed {
		logic [7:0] xctl;
		logic [7:0] pflg;
		logic [7:0] pen;
		logic [7:0] gctl;
		logic [7:0] rdata;
		ifer_req_s  req;
		logic       irq;
	} ifer_state_s;
	ifer_state_s st_q, st_d;

	logic pin1_evt;
	logic pin2_evt;
	logic [7:0] pflg_view;
	logic [7:0] set_p;
	logic global_irq_enable;
	logic req1, req2;
	logic [7:0] preq;

	ifer_edge u_pin1 (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.pin     (ext_pin1),
		.pulse   (pin1_evt)
	);
	ifer_edge u_pin2 (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.pin     (ext_pin2),
		.pulse   (pin2_evt)
	);

	always_comb begin
		set_p = '0;
		set_p[IFER_PF_PAR] = evt.par_done & ~PIN28;
		set_p[IFER_PF_ADC] = evt.adc_done;
		set_p[IFER_PF_SSP] = evt.ssp_done;
		set_p[IFER_PF_CCP] = evt.ccp_event & ~pwm_mode;
		set_p[IFER_PF_T2]  = evt.t2_match;
		set_p[IFER_PF_T1]  = evt.t1_ovf;
	end

	// rx/tx flags are live mirrors of the buffer states
	always_comb begin
		pflg_view = st_q.pflg & IFER_PFLG_STKY;
		pflg_view[IFER_PF_RX] = rx_buf_full;
		pflg_view[IFER_PF_TX] = tx_buf_empty;
		if (PIN28) begin
			pflg_view[IFER_PF_PAR] = 1'b0;
		end
	end

	assign global_irq_enable  = st_q.gctl[0];
	assign req1 = st_q.xctl[IFER_XCTL_F1] & st_q.xctl[IFER_XCTL_E1] & global_irq_enable;
	assign req2 = st_q.xctl[IFER_XCTL_F2] & st_q.xctl[IFER_XCTL_E2] & global_irq_enable;
	assign preq = pflg_view & st_q.pen & {8{global_irq_enable}};

	always_comb begin
		st_d = st_q;
		// software write; hardware set below wins over a clear
		if (reg_wr) begin
			unique case (reg_addr)
				IFER_OFS_XCTL: st_d.xctl = reg_wdata & IFER_XCTL_WMASK;
				IFER_OFS_PFLG: st_d.pflg = reg_wdata & IFER_PFLG_STKY;
				IFER_OFS_PEN:  st_d.pen  = reg_wdata;
				IFER_OFS_GCTL: st_d.gctl = {7'h00, reg_wdata[0]};
			endcase
		end
		st_d.xctl[IFER_XCTL_F1] = st_d.xctl[IFER_XCTL_F1] | pin1_evt;
		st_d.xctl[IFER_XCTL_F2] = st_d.xctl[IFER_XCTL_F2] | pin2_evt;
		st_d.pflg = st_d.pflg | set_p;
		st_d.rdata = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				IFER_OFS_XCTL: st_d.rdata = st_q.xctl & IFER_XCTL_WMASK;
				IFER_OFS_PFLG: st_d.rdata = pflg_view;
				IFER_OFS_PEN:  st_d.rdata = st_q.pen;
				IFER_OFS_GCTL: st_d.rdata = st_q.gctl;
			endcase
		end
		// priority routing of the pin requests, peripherals at high level
		st_d.req.hi = (req1 & st_q.xctl[IFER_XCTL_P1]) | (req2 & st_q.xctl[IFER_XCTL_P2]) | (|preq);
		st_d.req.lo = (req1 & ~st_q.xctl[IFER_XCTL_P1]) | (req2 & ~st_q.xctl[IFER_XCTL_P2]);
		st_d.irq = st_d.req.hi | st_d.req.lo;
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			st_q.xctl  <= IFER_XCTL_RST;
			st_q.pflg  <= IFER_PFLG_RST;
			st_q.pen   <= IFER_PEN_RST;
			st_q.gctl  <= IFER_GCTL_RST;
			st_q.rdata <= 8'h00;
			st_q.req   <= '0;
			st_q.irq   <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	assign reg_rdata = st_q.rdata;
	assign req       = st_q.req;
	assign irq       = st_q.irq;

	AST_FLAG_SETS_UNGATED: assert property (@(posedge ref_clk) disable iff (!reset_n)
		evt.t1_ovf |=> st_q.pflg[IFER_PF_T1])
		else $error("timer one flag missed its event");
	AST_FLAG_STICKY: assert property (@(posedge ref_clk) disable iff (!reset_n)
		st_q.pflg[IFER_PF_T1] && !(reg_wr && reg_addr == IFER_OFS_PFLG) |=> st_q.pflg[IFER_PF_T1])
		else $error("timer one flag dropped without a write");
	AST_ADC_SET: assert property (@(posedge ref_clk) disable iff (!reset_n)
		evt.adc_done |=> st_q.pflg[IFER_PF_ADC])
		else $error("conversion flag not set");
	AST_RESERVED_ZERO: assert property (@(posedge ref_clk) disable iff (!reset_n)
		reg_rd && reg_addr == IFER_OFS_XCTL |=> reg_rdata[5] == 1'b0 && reg_rdata[2] == 1'b0)
		else $error("reserved bit read as one");
	AST_RX_MIRROR: assert property (@(posedge ref_clk) disable iff (!reset_n)
		reg_rd && reg_addr == IFER_OFS_PFLG |=> reg_rdata[IFER_PF_RX] == $past(rx_buf_full))
		else $error("receive flag not mirroring buffer");
	AST_TX_MIRROR: assert property (@(posedge ref_clk) disable iff (!reset_n)
		reg_rd && reg_addr == IFER_OFS_PFLG |=> reg_rdata[IFER_PF_TX] == $past(tx_buf_empty))
		else $error("transmit flag not mirroring buffer");
	AST_PIN28_ZERO: assert property (@(posedge ref_clk) disable iff (!reset_n)
		PIN28 && reg_rd && reg_addr == IFER_OFS_PFLG |=> !reg_rdata[IFER_PF_PAR])
		else $error("parallel flag visible on small package");
	AST_PIN_FLAG: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$rose(u_pin1.st_q.s2) |=> st_q.xctl[IFER_XCTL_F1])
		else $error("pin one flag not set");
	AST_GATED_REQ: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!global_irq_enable |=> !req.lo)
		else $error("request without global enable");
	AST_PRIO: assert property (@(posedge ref_clk) disable iff (!reset_n)
		req1 && !st_q.xctl[IFER_XCTL_P1] |=> req.lo)
		else $error("low priority pin not routed low");
	AST_CCP_PWM: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!st_q.pflg[IFER_PF_CCP] && pwm_mode && !(reg_wr && reg_addr == IFER_OFS_PFLG) |=> !st_q.pflg[IFER_PF_CCP])
		else $error("capture flag set in pulse-width mode");
	AST_ENABLE_GATE: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!st_q.xctl[IFER_XCTL_E1] && !st_q.xctl[IFER_XCTL_E2] && !(|preq) |=> !irq)
		else $error("interrupt with pins disabled");
endmodule
`default_nettype wire

/* File: testbench/ifer_src.sv */
// far-side model: peripheral event pulses and external pin edges
// assumes go is a one-cycle request on ref_clk
`timescale 1ns/10ps
`default_nettype none
module ifer_src import ifer_pkg::*; (
	// clock
	input  wire logic       ref_clk,
	// request
	input  wire logic       go,
	input  wire logic [2:0] kind,
	// events
	output ifer_evt_s       evt,
	output logic            ext_pin1,
	output logic            ext_pin2
);
	logic [2:0] hold_q;
	logic [2:0] pk_q;
	initial begin
		evt = '0;
		hold_q = 3'h0;
		pk_q = 3'h0;
	end
	always @(posedge ref_clk) begin
		evt <= ifer_evt_s'((go && kind < 3'h6) ? (6'h20 >> kind) : 6'h00);
		if (go && kind >= 3'h6) begin
			hold_q <= 3'h4;
			pk_q <= kind;
		end else if (hold_q != 3'h0) begin
			hold_q <= hold_q - 3'h1;
		end
	end
	// held four cycles so the two-flop synchroniser cannot miss it
	assign ext_pin1 = (hold_q != 3'h0) && (pk_q == 3'h6);
	assign ext_pin2 = (hold_q != 3'h0) && (pk_q == 3'h7);
endmodule
`default_nettype wire

/* File: testbench/ifer_top_bench.sv */
// self-checking bench for the interrupt flag/enable register block
// assumes ifer_src drives events and pins
`timescale 1ns/10ps
`default_nettype none
module ifer_top_bench import ifer_pkg::*;;
	logic ref_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0;
	logic rx_buf_full = 1'b0, tx_buf_empty = 1'b0, pwm_mode = 1'b0, ext_pin1, ext_pin2, irq;
	logic [1:0] reg_addr = 2'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata;
	logic [2:0] kind = 3'h0;
	ifer_evt_s evt;
	ifer_req_s req;
	int errors = 0, compares = 0, cycles = 0;
	always #4 ref_clk = ~ref_clk;
	ifer_src SRC (.ref_clk(ref_clk), .go(go), .kind(kind), .evt(evt), .ext_pin1(ext_pin1), .ext_pin2(ext_pin2));
	ifer_top DUT (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_pin1(ext_pin1), .ext_pin2(ext_pin2),
		.evt(evt), .rx_buf_full(rx_buf_full), .tx_buf_empty(tx_buf_empty), .pwm_mode(pwm_mode),
		.req(req), .irq(irq));
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(logic [1:0] a, logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(logic [1:0] a, logic [7:0] exp, string what);
		@(posedge ref_clk);
		reg_rd <= 1'b1; reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		chk(what, exp, reg_rdata);
	endtask
	task automatic fire(logic [2:0] k);
		@(posedge ref_clk);
		go <= 1'b1; kind <= k;
		@(posedge ref_clk);
		go <= 1'b0;
		repeat (8) @(posedge ref_clk);
	endtask
	task automatic t_reset();
		rd(2'h0, IFER_XCTL_RST, "ext control");
		rd(2'h1, 8'h00, "flags");
		rd(2'h2, 8'h00, "enables");
		$display("test reset done");
	endtask
	task automatic t_flags();
		for (int k = 0; k < 6; k++) fire(3'(k));
		rd(2'h1, 8'hcf, "flags set, all disabled");
		wr(2'h1, 8'h00);
		rd(2'h1, 8'h00, "flags cleared");
		rx_buf_full <= 1'b1; tx_buf_empty <= 1'b1;
		wr(2'h1, 8'h00);
		rd(2'h1, 8'h30, "buffer mirrors");
		rx_buf_full <= 1'b0; tx_buf_empty <= 1'b0; pwm_mode <= 1'b1;
		fire(3'h3);
		rd(2'h1, 8'h00, "ccp in pwm");
		pwm_mode <= 1'b0;
		$display("test flags done");
	endtask
	task automatic t_ext();
		fire(3'h6);
		fire(3'h7);
		rd(2'h0, 8'hc3, "pin flags");
		wr(2'h0, 8'hff);
		rd(2'h0, 8'hdb, "unimplemented bits");
		wr(2'h0, 8'h00);
		rd(2'h0, 8'h00, "pin flags cleared");
		$display("test ext done");
	endtask
	task automatic t_irq();
		wr(2'h0, 8'h48);
		wr(2'h3, 8'h01);
		fire(3'h6);
		@(negedge ref_clk);
		chk("req after pin1", 8'h02, {6'h0, req});
		wr(2'h0, 8'h09);
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		chk("req low priority", 8'h01, {6'h0, req});
		wr(2'h3, 8'h00);
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		chk("irq gie off", 8'h00, {7'h0, irq});
		wr(2'h0, 8'h90);
		wr(2'h3, 8'h01);
		fire(3'h7);
		@(negedge ref_clk);
		chk("req after pin2", 8'h02, {6'h0, req});
		rd(2'h3, 8'h01, "global control");
		wr(2'h0, 8'h00);
		wr(2'h2, 8'h02);
		wr(2'h3, 8'h01);
		fire(3'h4);
		@(negedge ref_clk);
		chk("irq timer two", 8'h01, {7'h0, irq});
		$display("test irq done");
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			give_verdict();
		end
	end
	initial begin
		repeat (10) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_reset();
		t_flags();
		t_ext();
		t_irq();
		give_verdict();
	end
endmodule
`default_nettype wire
